// File: src/qsmdc_engine.sv
// chained-descriptor serial receive engine with avalon-mm register slave
// assumes one system clock, a dma controller on the same clock, miso from a pin
//
// Overview of operation
// - transfer length is descriptor bits 31:17, and zero means the transfer never ends on count.
// - bits 11:10 scale the length as bits, bytes, four-byte or sixteen-byte segments.
// - when a descriptor flagged last (bit 16) completes, the done status bit is set.
// - when a descriptor flagged neither last nor close completes, the next-index descriptor starts, no status.
// - the next index is bits 15:12 and may name the current descriptor to loop on it forever.
// - a transfer ending with its close bit (bit 9) set releases select, idles and signals dma done.
// - a transfer ending with close clear and no stop keeps select asserted and signals no dma done.
// - with receive dma on, dma service is requested for received data until length or dma stop.
// - receive dma field 0 means firmware drains, 1, 2 and 3 mean 1, 2 and 4 byte accesses.
// - the receive function runs only when descriptor bit 6 is set.
// - received data is stored only while receive is enabled.
`timescale 1ns/1ns
`default_nettype none
`include "qsmdc_params.svh"
module qsmdc_engine
    import qsmdc_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic miso_i,
    output qsmdc_spi_s spi_o,
    output qsmdc_dma_s dma_o,
    input wire logic dma_ack_i,
    input wire logic dma_term_i,
    output logic irq_o
);

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // length scaled to bits by the unit field
    function automatic logic [21:0] len_bits(input logic [31:0] d);
        logic [21:0] l;
        l = {7'h00, d[`QSMDC_LEN_HI:`QSMDC_LEN_LO]};
        case (d[`QSMDC_UNIT_HI:`QSMDC_UNIT_LO])
            2'h0: len_bits = l;
            2'h1: len_bits = l << 3;
            2'h2: len_bits = l << 5;
            default: len_bits = l << 7;
        endcase
    endfunction : len_bits

    // index of the last byte of a receive word for the dma field, firmware mode takes bytes
    function automatic logic [1:0] last_byte(input logic [1:0] f);
        case (f)
            2'h2: last_byte = 2'h1;
            2'h3: last_byte = 2'h3;
            default: last_byte = 2'h0;
        endcase
    endfunction : last_byte

    ////////////////////////////////////////////////////////////////////////////
    // state

    qsmdc_state_s q;
    qsmdc_state_s n;
    logic [31:0] cur_d;
    logic cur_last;
    logic cur_close;
    logic cur_rxen;
    logic [1:0] cur_rxdma;
    logic [3:0] cur_next;
    logic [21:0] exp_remain;
    logic desc_hit;
    logic [3:0] desc_idx;
    logic req;
    logic wr_go;
    logic stop_wr;

    // fields of the active descriptor, read live so software may patch the chain
    always_comb begin
        cur_d = q.desc[q.cur];
        cur_last = cur_d[`QSMDC_LAST_BIT];
        cur_close = cur_d[`QSMDC_CLOSE_BIT];
        cur_rxen = cur_d[`QSMDC_RXEN_BIT];
        cur_rxdma = cur_d[`QSMDC_RXDMA_HI:`QSMDC_RXDMA_LO];
        cur_next = cur_d[`QSMDC_NEXT_HI:`QSMDC_NEXT_LO];
        exp_remain = len_bits(cur_d);
        // sixteen word slots only, so offsets above the table do not alias onto it
        desc_hit = (avs_address_i[7:2] >= `QSMDC_DESC_IDX0)
            && (avs_address_i[7:2] <= `QSMDC_DESC_IDX0 + 6'h0F)
            && (avs_address_i[1:0] == 2'h0);
        desc_idx = 4'(avs_address_i[7:2] - `QSMDC_DESC_IDX0);
        req = avs_read_i || avs_write_i;
        // a write commits only in the cycle the master sees waitrequest low
        wr_go = avs_write_i && !q.wait_r;
        stop_wr = wr_go && (avs_address_i == `QSMDC_CTRL_OFS)
            && avs_writedata_i[`QSMDC_CTRL_STOP];
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state; bus first so that hardware sets below win over clears

    always_comb begin
        n = q;
        if (ce_i) begin
            n.dma.done = 1'b0;
            // two-flop pin synchroniser
            n.miso_m = miso_i;
            n.miso_s = q.miso_m;
            // one wait cycle per request; read data is set up in the wait cycle
            n.wait_r = 1'b1;
            if (req && q.wait_r) begin
                n.wait_r = 1'b0;
                n.rdata = 32'h0000_0000;
                if (desc_hit) begin
                    n.rdata = q.desc[desc_idx];
                end else begin
                    case (avs_address_i)
                        `QSMDC_STAT_OFS: n.rdata = {29'h0, q.st != ST_IDLE, q.sts[1:0]};
                        `QSMDC_MASK_OFS: n.rdata = {29'h0, q.mask};
                        `QSMDC_RXD_OFS: begin
                            n.rdata = q.rx_word;
                            if (avs_read_i) begin
                                n.rx_valid = 1'b0; // firmware pops the word
                            end
                        end
                        default: n.rdata = 32'h0000_0000;
                    endcase
                end
            end
            // writes land at the edge where the master samples waitrequest low
            if (wr_go) begin
                if (desc_hit) begin
                    n.desc[desc_idx] = avs_writedata_i;
                end else begin
                    case (avs_address_i)
                        `QSMDC_STAT_OFS: n.sts = q.sts & ~avs_writedata_i[2:0];
                        `QSMDC_MASK_OFS: n.mask = avs_writedata_i[2:0];
                        `QSMDC_CTRL_OFS: begin
                            if (avs_writedata_i[`QSMDC_CTRL_START] && q.st == ST_IDLE) begin
                                n.cur = avs_writedata_i[`QSMDC_CTRL_IDX_LO +: 4];
                                n.st = ST_LOAD;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
            // dma takes the word
            if (dma_ack_i && q.dma.req) begin
                n.rx_valid = 1'b0;
            end
            case (q.st)
                ST_IDLE: begin
                    n.spi.sclk = 1'b0;
                end
                ST_LOAD: begin
                    n.remain = exp_remain;
                    n.inf = (cur_d[`QSMDC_LEN_HI:`QSMDC_LEN_LO] == 15'h0000);
                    n.spi.cs_n = 1'b0;
                    n.div = 3'h0;
                    n.bitpos = 3'h0;
                    n.bcnt = 2'h0;
                    n.force_close = 1'b0;
                    n.st = ST_SHIFT;
                end
                ST_SHIFT: begin
                    if (q.div == 3'(`QSMDC_SCLK_HALF_CYC - 1)) begin
                        n.div = 3'h0;
                        n.spi.sclk = ~q.spi.sclk;
                        if (!q.spi.sclk) begin
                            // rising edge: sample, mode 0
                            if (!q.inf) begin
                                n.remain = q.remain - 22'h1;
                            end
                            if (cur_rxen) begin
                                n.sh = {q.sh[6:0], q.miso_s};
                                n.bitpos = q.bitpos + 3'h1;
                                if (q.bitpos == 3'h7) begin
                                    n.rx_word[q.bcnt * 8 +: 8] = {q.sh[6:0], q.miso_s};
                                    n.bcnt = q.bcnt + 2'h1;
                                    if (q.bcnt == last_byte(cur_rxdma)) begin
                                        n.bcnt = 2'h0;
                                        n.rx_valid = 1'b1;
                                        if (q.rx_valid && !(dma_ack_i && q.dma.req)) begin
                                            n.sts[`QSMDC_STAT_OVR] = 1'b1; // word lost
                                        end
                                    end
                                end
                            end
                        end else if (!q.inf && q.remain == 22'h0) begin
                            n.st = ST_END;
                        end
                    end else begin
                        n.div = q.div + 3'h1;
                    end
                    if (dma_term_i && cur_rxdma != 2'h0) begin
                        n.st = ST_END;
                    end
                end
                ST_END: begin
                    n.spi.sclk = 1'b0;
                    if (cur_last) begin
                        n.sts[`QSMDC_STAT_DONE] = 1'b1;
                    end
                    if (cur_close || q.force_close) begin
                        n.spi.cs_n = 1'b1;
                        n.dma.done = 1'b1;
                        n.st = ST_IDLE;
                    end else if (cur_last) begin
                        // open-ended last descriptor: select stays held
                        n.st = ST_IDLE;
                    end else begin
                        n.cur = cur_next;
                        n.st = ST_LOAD;
                    end
                end
                default: n.st = ST_IDLE;
            endcase
            // stop is applied after the state case so load and a chaining end cannot swallow it; an end going idle ignores it
            if (stop_wr && q.st != ST_IDLE && n.st != ST_IDLE) begin
                n.force_close = 1'b1;
                n.st = ST_END;
            end
            n.dma.size = cur_rxdma;
            n.dma.req = n.rx_valid && (cur_rxdma != 2'h0);
            n.irq = |(n.sts[1:0] & n.mask[1:0]);
        end
    end

    // single register bank; async reset loads constants only
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            q <= '0;
            q.desc <= {16{`QSMDC_DESC_RST}};
            q.spi.cs_n <= 1'b1;
            q.wait_r <= 1'b1;
            q.st <= ST_IDLE;
        end else begin
            q <= n;
        end
    end

    assign avs_readdata_o = q.rdata;
    assign avs_waitrequest_o = q.wait_r;
    assign spi_o = q.spi;
    assign dma_o = q.dma;
    assign irq_o = q.irq;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    property p_inf_len;
        @(posedge mclk_i) disable iff (!rst_b_i)
        (ce_i && q.st == ST_SHIFT && q.inf && !dma_term_i && !req) |=> (q.st == ST_SHIFT);
    endproperty
    a_inf_len: assert property (p_inf_len) else $error("zero length ended on count");

    property p_units;
        @(posedge mclk_i) disable iff (!rst_b_i)
        (ce_i && q.st == ST_LOAD) |=> (q.remain == $past(exp_remain));
    endproperty
    a_units: assert property (p_units) else $error("length not scaled by unit");

    property p_done;
        @(posedge mclk_i) disable iff (!rst_b_i)
        (ce_i && q.st == ST_END && cur_last) |=> q.sts[`QSMDC_STAT_DONE];
    endproperty
    a_done: assert property (p_done) else $error("done not set on last");

    property p_chain;
        @(posedge mclk_i) disable iff (!rst_b_i)
        (ce_i && q.st == ST_END && !cur_last && !cur_close && !q.force_close && !stop_wr)
        |=> (q.st == ST_LOAD) && (q.cur == $past(cur_next));
    endproperty
    a_chain: assert property (p_chain) else $error("next descriptor not taken");

    property p_self_loop;
        @(posedge mclk_i) disable iff (!rst_b_i)
        (ce_i && q.st == ST_END && !cur_last && !cur_close && cur_next == q.cur
            && !q.force_close && !stop_wr)
        |=> $stable(q.cur) ##1 (q.st == ST_SHIFT || !$past(ce_i) || $past(stop_wr));
    endproperty
    a_self_loop: assert property (p_self_loop) else $error("self loop broken");

    property p_close;
        @(posedge mclk_i) disable iff (!rst_b_i)
        (ce_i && q.st == ST_END && cur_close)
        |=> q.spi.cs_n && q.dma.done && (q.st == ST_IDLE);
    endproperty
    a_close: assert property (p_close) else $error("close did not release");

    property p_keep;
        @(posedge mclk_i) disable iff (!rst_b_i)
        (ce_i && q.st == ST_END && !cur_close && !q.force_close) |=> !q.spi.cs_n && !q.dma.done;
    endproperty
    a_keep: assert property (p_keep) else $error("select dropped without close");

    property p_dma_req;
        @(posedge mclk_i) disable iff (!rst_b_i)
        (ce_i && q.rx_valid && cur_rxdma != 2'h0 && !dma_ack_i && !req) |=> q.dma.req;
    endproperty
    a_dma_req: assert property (p_dma_req) else $error("no dma request");

    property p_size;
        @(posedge mclk_i) disable iff (!rst_b_i)
        ce_i |=> (q.dma.size == $past(cur_rxdma));
    endproperty
    a_size: assert property (p_size) else $error("dma size mismatch");

    property p_rx_off;
        @(posedge mclk_i) disable iff (!rst_b_i)
        (q.st == ST_SHIFT && !cur_rxen && !q.rx_valid) |=> !q.rx_valid;
    endproperty
    a_rx_off: assert property (p_rx_off) else $error("stored while receive off");

    property p_sclk_idle;
        @(posedge mclk_i) disable iff (!rst_b_i)
        (q.st == ST_IDLE) [*2] |-> !q.spi.sclk;
    endproperty
    a_sclk_idle: assert property (p_sclk_idle) else $error("clock runs idle");

    // the falling edge after the last counted bit must close the descriptor
    property p_len_end;
        @(posedge mclk_i) disable iff (!rst_b_i)
        (ce_i && q.st == ST_SHIFT && !q.inf && q.remain == 22'h0 && q.spi.sclk
            && q.div == 3'(`QSMDC_SCLK_HALF_CYC - 1)) |=> (q.st == ST_END);
    endproperty
    a_len_end: assert property (p_len_end) else $error("length end missed");

    property p_rx_word;
        @(posedge mclk_i) disable iff (!rst_b_i)
        (ce_i && q.st == ST_SHIFT && cur_rxen && !q.spi.sclk && q.bitpos == 3'h7
            && q.div == 3'(`QSMDC_SCLK_HALF_CYC - 1) && q.bcnt == last_byte(cur_rxdma))
        |=> q.rx_valid;
    endproperty
    a_rx_word: assert property (p_rx_word) else $error("full word not stored");

    property p_force_close;
        @(posedge mclk_i) disable iff (!rst_b_i)
        (ce_i && q.st == ST_END && q.force_close) |=> q.spi.cs_n && (q.st == ST_IDLE);
    endproperty
    a_force_close: assert property (p_force_close) else $error("stop did not close");

endmodule : qsmdc_engine
`default_nettype wire

// File: src/qsmdc_params.svh
// register offsets, descriptor field positions, reset values and timing for the
// chained-descriptor serial receive engine; assumes nothing beyond a 32-bit register bus
`ifndef QSMDC_PARAMS_SVH
`define QSMDC_PARAMS_SVH
`define QSMDC_CTRL_OFS 8'h00
`define QSMDC_STAT_OFS 8'h04
`define QSMDC_MASK_OFS 8'h08
`define QSMDC_RXD_OFS 8'h0C
`define QSMDC_DESC_OFS 8'h30
`define QSMDC_DESC_IDX0 6'h0C
`define QSMDC_DESC_RST 32'h0000_0000
`define QSMDC_LEN_HI 31
`define QSMDC_LEN_LO 17
`define QSMDC_LAST_BIT 16
`define QSMDC_NEXT_HI 15
`define QSMDC_NEXT_LO 12
`define QSMDC_UNIT_HI 11
`define QSMDC_UNIT_LO 10
`define QSMDC_CLOSE_BIT 9
`define QSMDC_RXDMA_HI 8
`define QSMDC_RXDMA_LO 7
`define QSMDC_RXEN_BIT 6
`define QSMDC_CTRL_START 0
`define QSMDC_CTRL_STOP 1
`define QSMDC_CTRL_IDX_LO 4
`define QSMDC_STAT_DONE 0
`define QSMDC_STAT_OVR 1
`define QSMDC_STAT_BUSY 2
`define QSMDC_CLK_NS 20
`define QSMDC_SCLK_HALF_NS 80
`define QSMDC_SCLK_HALF_CYC ((`QSMDC_SCLK_HALF_NS + `QSMDC_CLK_NS - 1) / `QSMDC_CLK_NS)
`endif

// File: src/qsmdc_pkg.sv
// types shared by the chained-descriptor serial receive engine
// assumes the constants header is included by the design files
package qsmdc_pkg;
    // gray order along idle -> load -> shift -> end
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOAD = 2'b01,
        ST_SHIFT = 2'b11,
        ST_END = 2'b10
    } qsmdc_state_e;

    typedef struct packed {
        logic req;
        logic done;
        logic [1:0] size;
    } qsmdc_dma_s;

    typedef struct packed {
        logic sclk;
        logic cs_n;
    } qsmdc_spi_s;

    typedef struct packed {
        logic [15:0][31:0] desc;
        logic [3:0] cur;
        qsmdc_state_e st;
        logic [2:0] div;
        qsmdc_spi_s spi;
        logic [21:0] remain;
        logic inf;
        logic force_close;
        logic [7:0] sh;
        logic [2:0] bitpos;
        logic [1:0] bcnt;
        logic [31:0] rx_word;
        logic rx_valid;
        logic [2:0] sts;
        logic [2:0] mask;
        logic irq;
        logic wait_r;
        logic [31:0] rdata;
        qsmdc_dma_s dma;
        logic miso_m;
        logic miso_s;
    } qsmdc_state_s;
endpackage : qsmdc_pkg

// File: tb/qsmdc_slave_model.sv
// serial slave model: sends a 32-bit pattern on miso, byte 0 first, msb first
// assumes mode 0 framing from the engine: select low, sclk idles low, sampled on rise
`timescale 1ns/1ns
`default_nettype none
module qsmdc_slave_model (
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic [31:0] pat_i,
    output logic miso_o
);
    logic [4:0] bitn_q = 5'h00;
    logic last_q = 1'b0;
    logic cur;
    ////////////////////////////////////////////////////////////////////////////////////////
    // shift on the falling edge so the bit has half a period to cross the synchroniser
    always @(negedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            bitn_q <= 5'h00;
        end else begin
            last_q <= cur;
            bitn_q <= bitn_q + 5'h01;
        end
    end
    assign cur = pat_i[{bitn_q[4:3], ~bitn_q[2:0]}];
    // the line has no pull: when deselected show the inverse, never a stale copy
    assign miso_o = cs_n_i ? ~last_q : cur;
endmodule : qsmdc_slave_model
`default_nettype wire

// File: tb/qsmdc_engine_tb.sv
// self-checking bench: avalon register tasks, serial slave model, auto-acking dma
// assumes the engine's one-wait-cycle slave and an 8-cycle serial clock
`timescale 1ns/1ns
`default_nettype none
`include "qsmdc_params.svh"
module qsmdc_engine_tb import qsmdc_pkg::*;;
    logic mclk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [7:0] avs_address_i = 8'h00;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0000_0000;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic miso_i;
    qsmdc_spi_s spi_o;
    qsmdc_dma_s dma_o;
    logic dma_ack_i = 1'b0;
    logic dma_term_i = 1'b0;
    logic ce_i = 1'b1;
    logic irq_o;
    logic ack_en = 1'b0;
    logic [31:0] pat = 32'h0000_0000;
    logic [31:0] q;
    logic cs_prev = 1'b1;
    int failures = 0;
    int checked = 0;
    int cs_rises = 0;
    int dones = 0;
    int acks = 0;
    qsmdc_engine u_qsmdc_engine (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .miso_i(miso_i), .spi_o(spi_o), .dma_o(dma_o),
        .dma_ack_i(dma_ack_i), .dma_term_i(dma_term_i), .irq_o(irq_o));
    qsmdc_slave_model u_qsmdc_slave_model (.cs_n_i(spi_o.cs_n), .sclk_i(spi_o.sclk),
        .pat_i(pat), .miso_o(miso_i));
    initial begin
        forever #10 mclk_i = ~mclk_i;
    end
    ////////////////////////////////////////////////////////////////////////////////////////
    // dma stand-in acks each word once; counters watch select, close pulses and pops
    always @(posedge mclk_i) begin
        dma_ack_i <= ack_en & dma_o.req & ~dma_ack_i;
        acks += int'(dma_ack_i & dma_o.req);
        dones += int'(dma_o.done);
        cs_rises += int'(spi_o.cs_n & ~cs_prev);
        cs_prev = spi_o.cs_n;
    end
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic hang();
        failures++;
        $display("FAIL %0t wait ran out", $time);
        tally_and_finish();
    endtask : hang
    // one avalon transfer; held until waitrequest is sampled low, data taken at that edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= wr;
        avs_read_i <= ~wr;
        do begin
            @(posedge mclk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 50);
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        if (n >= 50) hang();
    endtask : bus
    task automatic wait_stat(input int b, input logic v);
        int i;
        for (i = 0; i < 600; i++) begin
            bus(1'b0, `QSMDC_STAT_OFS, 32'h0);
            if (q[b] === v) return;
        end
        hang();
    endtask : wait_stat
    function automatic logic [31:0] dsc(input int len, input int last, input int nxt,
        input int un, input int cls, input int dma, input int rxen);
        return {len[14:0], last[0], nxt[3:0], un[1:0], cls[0], dma[1:0], rxen[0], 6'h00};
    endfunction : dsc
    task automatic go(input logic [3:0] idx);
        bus(1'b1, `QSMDC_STAT_OFS, 32'h3);
        cs_rises = 0;
        dones = 0;
        acks = 0;
        bus(1'b1, `QSMDC_CTRL_OFS, {24'h0, idx, 4'h1});
    endtask : go
    // program one slot, run it to the done flag, then count pops, closes and releases
    task automatic run(input logic [3:0] idx, input logic [31:0] d, input int n);
        bus(1'b1, 8'h30 + {2'b00, idx, 2'b00}, d);
        go(idx);
        wait_stat(`QSMDC_STAT_DONE, 1'b1);
        chk(q, 32'h1);
        chk(32'(acks), 32'(n));
        chk(32'(dones + 4 * cs_rises), 32'h5);
    endtask : run
    ////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        chk({28'h0, spi_o.cs_n, spi_o.sclk, irq_o, dma_o.req}, 32'h8);
        bus(1'b0, `QSMDC_DESC_OFS, 32'h0);
        chk(q, `QSMDC_DESC_RST);
        bus(1'b1, 8'h6C, 32'hFFFF_FFC0);
        bus(1'b0, 8'h6C, 32'h0);
        chk(q, 32'hFFFF_FFC0);
        bus(1'b1, 8'h20, 32'h1234_5678);
        bus(1'b0, 8'h20, 32'h0);
        chk(q, 32'h0);
        bus(1'b1, 8'h70, 32'hFFFF_FFC0);
        bus(1'b0, `QSMDC_DESC_OFS, 32'h0);
        chk(q, `QSMDC_DESC_RST);
        // one byte, firmware drains, irq raised, masked and cleared
        pat = 32'h0000_00A5;
        bus(1'b1, `QSMDC_MASK_OFS, 32'h1);
        run(4'h0, dsc(1, 1, 0, 1, 1, 0, 1), 0);
        chk({30'h0, spi_o.cs_n, irq_o}, 32'h3);
        bus(1'b0, `QSMDC_RXD_OFS, 32'h0);
        chk(q & 32'hFF, 32'hA5);
        bus(1'b1, `QSMDC_MASK_OFS, 32'h0);
        repeat (2) @(posedge mclk_i);
        chk({31'h0, irq_o}, 32'h0);
        bus(1'b1, `QSMDC_MASK_OFS, 32'h1);
        bus(1'b1, `QSMDC_STAT_OFS, 32'h1);
        repeat (2) @(posedge mclk_i);
        chk({31'h0, irq_o}, 32'h0);
        // chain of two, select held between; dma on for every size and for unit codes 0, 1 and 3
        ack_en = 1'b1;
        bus(1'b1, 8'h38, dsc(2, 1, 0, 1, 1, 2, 1));
        run(4'h1, dsc(16, 0, 2, 0, 0, 2, 1), 2);
        run(4'h0, dsc(3, 1, 0, 1, 1, 1, 1), 3);
        run(4'h0, dsc(1, 1, 0, 3, 1, 3, 1), 4);
        run(4'h0, dsc(2, 1, 0, 1, 1, 1, 0), 0);
        // four bytes left for firmware, size field shown to the dma
        ack_en = 1'b0;
        pat = 32'hDEAD_BEEF;
        bus(1'b1, `QSMDC_DESC_OFS, dsc(1, 1, 0, 2, 1, 3, 1));
        go(4'h0);
        wait_stat(`QSMDC_STAT_DONE, 1'b1);
        chk({29'h0, dma_o.req, dma_o.size}, 32'h7);
        bus(1'b0, `QSMDC_RXD_OFS, 32'h0);
        chk(q, 32'hDEAD_BEEF);
        repeat (2) @(posedge mclk_i);
        chk({31'h0, dma_o.req}, 32'h0);
        // zero length runs until the dma terminates
        ack_en = 1'b1;
        bus(1'b1, `QSMDC_DESC_OFS, dsc(0, 1, 0, 1, 1, 1, 1));
        go(4'h0);
        repeat (400) @(posedge mclk_i);
        // clock enable low freezes every output, link and bus alike
        ce_i <= 1'b0;
        @(posedge mclk_i);
        q = {24'h0, spi_o, dma_o, irq_o, avs_waitrequest_o};
        repeat (20) @(posedge mclk_i);
        chk({24'h0, spi_o, dma_o, irq_o, avs_waitrequest_o}, q);
        ce_i <= 1'b1;
        bus(1'b0, `QSMDC_STAT_OFS, 32'h0);
        chk({q[30:0], spi_o.cs_n}, 32'h8);
        dma_term_i <= 1'b1;
        wait_stat(`QSMDC_STAT_DONE, 1'b1);
        dma_term_i <= 1'b0;
        repeat (4) @(posedge mclk_i);
        chk({28'h0, q[2:0], spi_o.cs_n}, 32'h3);
        // slot pointing at itself loops with select held until stopped
        bus(1'b1, 8'h44, dsc(1, 0, 5, 1, 0, 0, 0));
        go(4'h5);
        repeat (600) @(posedge mclk_i);
        bus(1'b0, `QSMDC_STAT_OFS, 32'h0);
        chk({q[30:0], spi_o.cs_n}, 32'h8);
        chk(32'(cs_rises + dones), 32'h0);
        bus(1'b1, `QSMDC_CTRL_OFS, 32'h2);
        wait_stat(`QSMDC_STAT_BUSY, 1'b0);
        repeat (4) @(posedge mclk_i);
        chk({31'h0, spi_o.cs_n}, 32'h1);
        tally_and_finish();
    end
endmodule : qsmdc_engine_tb
`default_nettype wire
